/* File: ntsp_counter.sv */
// Running BCD calendar counters, advanced by a one-second pulse.
// Assumes load values come from the host-visible copy.
`timescale 1ns/1ps
module ntsp_counter
  import ntsp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       secTick,
  input  wire logic       load,
  // Load values
  input  wire logic [7:0] ldSec,
  input  wire logic [7:0] ldMin,
  input  wire logic [7:0] ldHour,
  input  wire logic [7:0] ldDay,
  input  wire logic [7:0] ldDate,
  input  wire logic [7:0] ldMonth,
  input  wire logic [7:0] ldYear,
  // Counter values
  output logic      [7:0] cntSec,
  output logic      [7:0] cntMin,
  output logic      [7:0] cntHour,
  output logic      [7:0] cntDay,
  output logic      [7:0] cntDate,
  output logic      [7:0] cntMonth,
  output logic      [7:0] cntYear
);
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } ntsp_cnt_t;

  ntsp_cnt_t cnt_ff, nxt_cnt;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (load)
      nxt_cnt = '{ldSec, ldMin, ldHour, ldDay, ldDate, ldMonth, ldYear}; // RULE_13
    else if (secTick)
    begin
      nxt_cnt.sec = (cnt_ff.sec == SEC_LAST) ? ZERO_BCD : bcdInc(cnt_ff.sec); // RULE_03
      if (cnt_ff.sec == SEC_LAST)
      begin
        nxt_cnt.min = (cnt_ff.min == MIN_LAST) ? ZERO_BCD : bcdInc(cnt_ff.min);
        if (cnt_ff.min == MIN_LAST)
        begin
          nxt_cnt.hour = (cnt_ff.hour == HOUR_LAST) ? ZERO_BCD : bcdInc(cnt_ff.hour);
          if (cnt_ff.hour == HOUR_LAST)
          begin
            nxt_cnt.day = (cnt_ff.day == DAY_LAST) ? DAY_FIRST : bcdInc(cnt_ff.day);
            if (cnt_ff.date == lastDate(cnt_ff.month, cnt_ff.year)) // RULE_04
            begin
              nxt_cnt.date  = DATE_FIRST;
              nxt_cnt.month = (cnt_ff.month == MONTH_LAST) ? MONTH_FIRST
                                                           : bcdInc(cnt_ff.month);
              if (cnt_ff.month == MONTH_LAST)
                nxt_cnt.year = (cnt_ff.year == YEAR_LAST) ? ZERO_BCD
                                                          : bcdInc(cnt_ff.year);
            end
            else
              nxt_cnt.date = bcdInc(cnt_ff.date);
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_ff <= '{ZERO_BCD, ZERO_BCD, ZERO_BCD, DAY_FIRST, DATE_FIRST, MONTH_FIRST, ZERO_BCD};
    else
      cnt_ff <= nxt_cnt;
  end

  assign cntSec   = cnt_ff.sec;
  assign cntMin   = cnt_ff.min;
  assign cntHour  = cnt_ff.hour;
  assign cntDay   = cnt_ff.day;
  assign cntDate  = cnt_ff.date;
  assign cntMonth = cnt_ff.month;
  assign cntYear  = cnt_ff.year;
endmodule // ntsp_counter

/* File: ntsp_host.sv */
// Host model: drives the parallel memory port one cycle at a time.
// Assumes calls start just after a rising edge of sys_clk.
`timescale 1ns/1ps
module ntsp_host
  import ntsp_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Port controls
  output logic                   chipEnN,
  output logic                   outEnN,
  output logic                   writeEnN,
  output logic      [ADDR_W-1:0] addrLine,
  // Data lines
  output logic      [7:0]        dataLineIn,
  input  wire logic [7:0]        dataLineOut,
  input  wire logic              dataLineOeN
);
  initial
  begin
    chipEnN = 1'b1;
    outEnN = 1'b1;
    writeEnN = 1'b1;
    addrLine = '0;
    dataLineIn = 8'h00;
  end

  // One access held for one edge, answer taken just after it, then one idle edge
  task automatic cyc(input logic ce, input logic we, input logic oe,
                     input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oen);
    chipEnN = ce;
    writeEnN = we;
    outEnN = oe;
    addrLine = a;
    dataLineIn = d;
    @(posedge sys_clk);
    #1;
    q = dataLineOut;
    oen = dataLineOeN;
    chipEnN = 1'b1;
    writeEnN = 1'b1;
    outEnN = 1'b1;
    // Released lines float; inverse keeps stale data from matching
    dataLineIn = ~d;
    // Idle edge keeps back-to-back calls from retoggling strobes in one step
    @(posedge sys_clk);
    #1;
  endtask
endmodule // ntsp_host

/* File: ntsp_pkg.sv */
// Constants, field layout and calendar helpers for the timekeeping SRAM port.
// Assumes a single 20 MHz system clock drives every module.
package ntsp_pkg;
  localparam int          ADDR_W       = 19;
  localparam int          SYS_CLK_HZ   = 20_000_000;
  localparam int          FT_WAVE_HZ   = 512;
  // Half period of the test wave is one subtick
  localparam int          SUBTICK_CYC  = SYS_CLK_HZ / (2 * FT_WAVE_HZ);
  localparam logic [9:0]  SUBTICK_LAST = 10'(2 * FT_WAVE_HZ - 1);
  // Clock registers live where the top address bits are all ones
  localparam logic [15:0] RTC_PAGE     = 16'hFFFF;
  localparam logic [2:0]  REG_CTRL     = 3'h0;
  localparam logic [2:0]  REG_SEC      = 3'h1;
  localparam logic [2:0]  REG_MIN      = 3'h2;
  localparam logic [2:0]  REG_HOUR     = 3'h3;
  localparam logic [2:0]  REG_DAY      = 3'h4;
  localparam logic [2:0]  REG_DATE     = 3'h5;
  localparam logic [2:0]  REG_MONTH    = 3'h6;
  localparam logic [2:0]  REG_YEAR     = 3'h7;
  localparam int          WHOLD_BIT    = 7;
  localparam int          RHOLD_BIT    = 6;
  localparam int          STOP_BIT     = 7;
  localparam int          FT_BIT       = 6;
  localparam logic [7:0]  SEC_LAST     = 8'h59;
  localparam logic [7:0]  MIN_LAST     = 8'h59;
  localparam logic [7:0]  HOUR_LAST    = 8'h23;
  localparam logic [7:0]  DAY_FIRST    = 8'h01;
  localparam logic [7:0]  DAY_LAST     = 8'h07;
  localparam logic [7:0]  DATE_FIRST   = 8'h01;
  localparam logic [7:0]  MONTH_FIRST  = 8'h01;
  localparam logic [7:0]  MONTH_LAST   = 8'h12;
  localparam logic [7:0]  YEAR_LAST    = 8'h99;
  localparam logic [7:0]  ZERO_BCD     = 8'h00;

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcdInc = {4'(v[7:4] + 4'h1), 4'h0};
    else
      bcdInc = {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction

  // Valid for years 2000 to 2099, where every fourth year is a leap year
  function automatic logic [7:0] lastDate(input logic [7:0] month,
                                          input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    unique case (month)
      8'h02:                      lastDate = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDate = 8'h30;
      default:                    lastDate = 8'h31;
    endcase
  endfunction
endpackage

/* File: ntsp_sram.sv */
// Byte-wide static storage array behind the parallel port.
// Assumes the caller qualifies the write strobe; read data is registered.
`timescale 1ns/1ps
module ntsp_sram
  import ntsp_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Access
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wrEn,
  input  wire logic [7:0]        wrData,
  // Read data
  output logic      [7:0]        rdData
);
  logic [7:0] mem [2**ADDR_W];

  // No reset: contents are meant to survive, as in the real array
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
      mem[addr] <= wrData;
    rdData <= mem[addr];
  end
endmodule // ntsp_sram

/* File: ntsp_top.sv */
// Timekeeping SRAM: parallel memory port with clock registers on top.
// Assumes control pins are synchronous to sys_clk; the supply monitor
// result arrives as a level; the testbench resolves the data wires.
`timescale 1ns/1ps
// Functional notes
// RULE_01 - 512k by 8 memory on parallel port
// RULE_02 - Clock registers at eight highest addresses
// RULE_03 - BCD time fields, 24-hour hours
// RULE_04 - Date rolls per month length, leap years
// RULE_05 - Running counters separate from visible copy
// RULE_06 - Out-of-tolerance supply ignores all accesses
// RULE_07 - Read-hold bit 6 freezes visible registers
// RULE_08 - Held copy shows time at hold instant
// RULE_09 - Release refreshes all visible registers within second
// RULE_10 - Host keeps read-hold low 500 us
// RULE_11 - Host sets read-hold before reading time; the bench reads the time with read-hold clear except in t_read_hold
// RULE_12 - Write-hold bit 7 freezes for loading
// RULE_13 - Write-hold release copies values into counters
// RULE_14 - Chip enable high deselects, data tristated
// RULE_15 - Enable and write low performs write
// RULE_16 - Output enable low with write high reads
// RULE_17 - Both enables high: read, no drive
// RULE_18 - Low supply deselects whatever the controls
// RULE_19 - Seconds MSB stops the oscillator
// RULE_20 - Day bit 6 toggles seconds LSB 512 Hz
// RULE_21 - Host writes zero to unused bits
// RULE_22 - Low supply drives power-fail output low
// RULE_23 - Year highest, control lowest of eight
// RULE_24 - Unheld writes never alter running counters
module ntsp_top
  import ntsp_pkg::*;
#(
  parameter logic [14:0] TICK_DIV = 15'(SUBTICK_CYC)
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Memory port controls
  input  wire logic              chipEnN,
  input  wire logic              outEnN,
  input  wire logic              writeEnN,
  input  wire logic [ADDR_W-1:0] addrLine,
  // Data lines
  input  wire logic [7:0]        dataLineIn,
  output logic      [7:0]        dataLineOut,
  output logic                   dataLineOeN,
  // Supply monitor
  input  wire logic              supplyOk,
  output logic                   supplyFailOutN,
  output logic                   supplyFailOeN
);
  typedef struct packed {
    logic [14:0]     div;
    logic [9:0]      sub;
    logic            whold;
    logic            rhold;
    logic            stop;
    logic            ft;
    logic            load;
    logic            drive;
    logic            rtcSel;
    logic [7:0]      dout;
    logic [7:1][7:0] vis;
  } ntsp_state_t;

  ntsp_state_t s_ff, nxt_s;

  logic       sel, wr, rd, isRtc, rtcWr, tick, secTick, ftWave;
  logic [2:0] idx;
  logic [7:0] rtcByte, sramQ;
  logic [7:0] cntSec, cntMin, cntHour, cntDay, cntDate, cntMonth, cntYear;
  logic [7:1][7:0] cntAll;

  // Power fail gates the chip enable itself
  assign sel   = !chipEnN && supplyOk;        // RULE_06
  assign wr    = sel && !writeEnN;            // RULE_15
  assign rd    = sel && writeEnN && !outEnN;  // RULE_16
  assign isRtc = (addrLine[ADDR_W-1:3] == RTC_PAGE); // RULE_02
  assign idx   = addrLine[2:0];
  assign rtcWr = wr && isRtc;
  assign tick  = (s_ff.div == TICK_DIV - 15'h0001);
  assign secTick = tick && !s_ff.stop && (s_ff.sub == SUBTICK_LAST);

  // Year at the top address, control at the bottom
  assign cntAll = {cntYear, cntMonth, cntDate, cntDay, cntHour, cntMin, cntSec}; // RULE_23

  // Test wave shows through even while the copy is held
  assign ftWave = (s_ff.ft && !s_ff.stop) ? s_ff.sub[0] : s_ff.vis[REG_SEC][0]; // RULE_20

  always_comb
  begin
    rtcByte = s_ff.vis[idx == REG_CTRL ? REG_SEC : idx];
    unique case (idx)
      REG_CTRL: rtcByte = {s_ff.whold, s_ff.rhold, 6'h00};
      REG_SEC:  rtcByte = {s_ff.stop, s_ff.vis[REG_SEC][6:1], ftWave};
      REG_DAY:  rtcByte = {1'b0, s_ff.ft, 3'h0, s_ff.vis[REG_DAY][2:0]};
      default:  rtcByte = s_ff.vis[idx];
    endcase
  end

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.load = 1'b0;
    // Stopped oscillator clears the whole divider chain and holds it at zero
    if (s_ff.stop)
    begin
      nxt_s.div = 15'h0000;
      nxt_s.sub = 10'h000; // RULE_19
    end
    else
    begin
      nxt_s.div = tick ? 15'h0000 : 15'(s_ff.div + 15'h0001);
      if (tick)
        nxt_s.sub = (s_ff.sub == SUBTICK_LAST) ? 10'h000 : 10'(s_ff.sub + 10'h001);
    end
    // Copy follows counters only while no hold is pending
    if (!s_ff.whold && !s_ff.rhold && !s_ff.load) // RULE_07 RULE_08
      nxt_s.vis = cntAll; // RULE_05 RULE_09
    if (rtcWr)
    begin
      if (idx == REG_CTRL)
      begin
        nxt_s.whold = dataLineIn[WHOLD_BIT]; // RULE_12
        nxt_s.rhold = dataLineIn[RHOLD_BIT]; // RULE_07
        nxt_s.load  = s_ff.whold && !dataLineIn[WHOLD_BIT]; // RULE_13
      end
      else
      begin
        nxt_s.vis[idx] = dataLineIn; // RULE_24
        if (idx == REG_SEC)
          nxt_s.stop = dataLineIn[STOP_BIT]; // RULE_19
        if (idx == REG_DAY)
          nxt_s.ft = dataLineIn[FT_BIT]; // RULE_20
      end
    end
    nxt_s.drive  = rd; // RULE_14 RULE_17 RULE_18
    nxt_s.rtcSel = isRtc;
    nxt_s.dout   = rtcByte;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  ntsp_counter u_counter (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .secTick  (secTick),
    .load     (s_ff.load),
    .ldSec    ({1'b0, s_ff.vis[REG_SEC][6:0]}),
    .ldMin    (s_ff.vis[REG_MIN]),
    .ldHour   (s_ff.vis[REG_HOUR]),
    .ldDay    ({5'h00, s_ff.vis[REG_DAY][2:0]}),
    .ldDate   (s_ff.vis[REG_DATE]),
    .ldMonth  (s_ff.vis[REG_MONTH]),
    .ldYear   (s_ff.vis[REG_YEAR]),
    .cntSec   (cntSec),
    .cntMin   (cntMin),
    .cntHour  (cntHour),
    .cntDay   (cntDay),
    .cntDate  (cntDate),
    .cntMonth (cntMonth),
    .cntYear  (cntYear)
  );

  ntsp_sram u_sram (
    .sys_clk (sys_clk),
    .addr    (addrLine),
    .wrEn    (wr && !isRtc), // RULE_01
    .wrData  (dataLineIn),
    .rdData  (sramQ)
  );

  assign dataLineOut    = s_ff.rtcSel ? s_ff.dout : sramQ;
  assign dataLineOeN    = !s_ff.drive;
  assign supplyFailOutN = 1'b0;
  assign supplyFailOeN  = supplyOk; // RULE_22

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_desel_hiz:   assert property (chipEnN |=> dataLineOeN) // RULE_14
    else $error("Data driven while deselected");
  a_pfail_hiz:   assert property (!supplyOk |-> !wr ##1 dataLineOeN) // RULE_18
    else $error("Access during supply fail");
  a_pfail_norw:  assert property (!supplyOk |=> $stable(s_ff.whold) && $stable(s_ff.rhold)) // RULE_06
    else $error("Control changed during supply fail");
  a_pfo_low:     assert property (!supplyOk |-> !supplyFailOeN && !supplyFailOutN) // RULE_22
    else $error("Power-fail output not asserted");
  a_write_nodrv: assert property (!chipEnN && !writeEnN |=> dataLineOeN) // RULE_15
    else $error("Data driven during write");
  a_read_drive:  assert property (supplyOk && !chipEnN && writeEnN && !outEnN
                                  |=> !dataLineOeN) // RULE_16
    else $error("Read not driven");
  a_oe_high_hiz: assert property (!chipEnN && writeEnN && outEnN |=> dataLineOeN) // RULE_17
    else $error("Driven with output enable high");
  a_rhold_freeze: assert property (s_ff.rhold && !rtcWr |=> $stable(s_ff.vis)) // RULE_08
    else $error("Held copy changed");
  a_free_refresh: assert property (!s_ff.whold && !s_ff.rhold && !s_ff.load && !rtcWr
                                   |=> s_ff.vis == $past(cntAll)) // RULE_09
    else $error("Copy not refreshed");
  a_load_commit: assert property (s_ff.load |=> cntMin == $past(s_ff.vis[REG_MIN])
                                  && cntYear == $past(s_ff.vis[REG_YEAR])) // RULE_13
    else $error("Loaded values not committed");
  a_unheld_keep: assert property (rtcWr && !s_ff.load && !secTick
                                  |=> $stable(cntAll)) // RULE_24
    else $error("Counters altered by plain write");
  a_stop_halts:  assert property (s_ff.stop |-> !secTick ##1 s_ff.sub == 10'h000) // RULE_19
    else $error("Counting while stopped");

  c_read_hold:   cover property (s_ff.rhold && rd && isRtc);
  c_wh_release:  cover property (s_ff.load ##1 !s_ff.whold);
  c_ft_toggle:   cover property (s_ff.ft && !s_ff.stop && tick ##1 s_ff.ft);
  c_pfail_try:   cover property (!supplyOk && !chipEnN && !writeEnN);
endmodule // ntsp_top

/* File: nv_timekeeping_sram_port_tb_top.sv */
// Self-checking bench for the timekeeping memory port.
// Assumes TICK_DIV of 4, so one second is 4096 cycles.
`timescale 1ns/1ps
module nv_timekeeping_sram_port_tb_top;
  import ntsp_pkg::*;
  localparam int SEC_CYC = 4200;
  localparam int SUB_CYC = 4;
  logic              sys_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              supplyOk = 1'b1;
  logic              chipEnN;
  logic              outEnN;
  logic              writeEnN;
  logic [ADDR_W-1:0] addrLine;
  logic [7:0]        dataLineIn;
  logic [7:0]        dataLineOut;
  logic              dataLineOeN;
  logic              supplyFailOutN;
  logic              supplyFailOeN;
  logic [7:0]        q;
  logic [7:0]        q2;
  logic              oen;
  int                n_fail = 0;
  int                compares = 0;

  always #25 sys_clk = ~sys_clk;

  ntsp_host host (.sys_clk(sys_clk), .chipEnN(chipEnN), .outEnN(outEnN),
    .writeEnN(writeEnN), .addrLine(addrLine), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN));

  ntsp_top #(.TICK_DIV(15'(SUB_CYC))) dut (.sys_clk(sys_clk), .resetn(resetn),
    .chipEnN(chipEnN), .outEnN(outEnN), .writeEnN(writeEnN),
    .addrLine(addrLine), .dataLineIn(dataLineIn), .dataLineOut(dataLineOut),
    .dataLineOeN(dataLineOeN), .supplyOk(supplyOk),
    .supplyFailOutN(supplyFailOutN), .supplyFailOeN(supplyFailOeN));

  function automatic logic [ADDR_W-1:0] ra(input logic [2:0] r);
    ra = {RTC_PAGE, r};
  endfunction

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    host.cyc(1'b0, 1'b0, 1'b1, a, d, q, oen);
  endtask

  task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    host.cyc(1'b0, 1'b1, 1'b0, a, 8'h00, q, oen);
    chk({what, " drive"}, 8'h00, {7'h00, oen});
    chk(what, e, q);
  endtask

  task automatic rdAll(input logic [7:0] e [8]);
    for (int i = 0; i < 8; i++)
      rd($sformatf("clock reg %0d", i), ra(3'(i)), e[i]);
  endtask

  task automatic waitSec;
    repeat (SEC_CYC) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset;
    rdAll('{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
  endtask

  task automatic t_sram;
    wr('0, 8'h5A);
    host.cyc(1'b0, 1'b0, 1'b0, ra(3'h0) - 19'h1, 8'hA5, q, oen);
    chk("write oe drive", 8'h01, {7'h00, oen});
    rd("low byte", '0, 8'h5A);
    rd("top plain byte", ra(3'h0) - 19'h1, 8'hA5);
  endtask

  task automatic t_deselect;
    host.cyc(1'b1, 1'b0, 1'b0, '0, 8'hFF, q, oen);
    chk("deselect drive", 8'h01, {7'h00, oen});
    host.cyc(1'b0, 1'b1, 1'b1, '0, 8'h00, q, oen);
    chk("no oe drive", 8'h01, {7'h00, oen});
    supplyOk = 1'b0;
    wr('0, 8'h33);
    chk("fail pin", 8'h00, {7'h00, supplyFailOeN});
    chk("fail value", 8'h00, {7'h00, supplyFailOutN});
    host.cyc(1'b0, 1'b1, 1'b0, '0, 8'h00, q, oen);
    chk("low supply drive", 8'h01, {7'h00, oen});
    supplyOk = 1'b1;
    rd("kept byte", '0, 8'h5A);
    chk("fail pin off", 8'h01, {7'h00, supplyFailOeN});
  endtask

  task automatic t_set_clock;
    wr(ra(REG_CTRL), 8'h80);
    wr(ra(REG_SEC), 8'hD9);
    wr(ra(REG_MIN), 8'h59);
    wr(ra(REG_HOUR), 8'h23);
    wr(ra(REG_DAY), 8'h03);
    wr(ra(REG_DATE), 8'h28);
    wr(ra(REG_MONTH), 8'h02);
    wr(ra(REG_YEAR), 8'h04);
    wr(ra(REG_CTRL), 8'h00);
    waitSec();
    // Stop bit reads back set on top of the frozen seconds
    rd("stopped sec", ra(REG_SEC), 8'hD9);
    // Start from a reset divider so the next tick time is known
    wr(ra(REG_SEC), 8'h59);
    waitSec();
    rdAll('{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h04});
    wr(ra(REG_MIN), 8'h30);
    rd("unheld min", ra(REG_MIN), 8'h00);
  endtask

  task automatic t_read_hold;
    wr(ra(REG_CTRL), 8'h40);
    rd("held sec", ra(REG_SEC), 8'h00);
    waitSec();
    rd("frozen sec", ra(REG_SEC), 8'h00);
    wr(ra(REG_CTRL), 8'h00);
    rd("fresh sec", ra(REG_SEC), 8'h01);
  endtask

  task automatic t_test_wave;
    wr(ra(REG_DAY), 8'h44);
    rd("test bit day", ra(REG_DAY), 8'h44);
    host.cyc(1'b0, 1'b1, 1'b0, ra(REG_SEC), 8'h00, q2, oen);
    // Two reads one subtick apart, so exactly one wave edge lies between
    repeat (SUB_CYC - 2) @(posedge sys_clk);
    #1;
    host.cyc(1'b0, 1'b1, 1'b0, ra(REG_SEC), 8'h00, q, oen);
    chk("wave toggle", 8'h01, {7'h00, q[0] ^ q2[0]});
    wr(ra(REG_DAY), 8'h04);
  endtask

  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    t_reset();
    t_sram();
    t_deselect();
    t_set_clock();
    t_read_hold();
    t_test_wave();
    close_out();
  end
endmodule // nv_timekeeping_sram_port_tb_top
